// *** pkg/dl_pkg.sv ***
// Constants and carrier types for the diagnostic event logger.
// Assumes one synchronous clock domain and synchronous inputs.
package dl_pkg;

   // ---------------------------------------------------------------
   // History shapes
   // ---------------------------------------------------------------
   localparam int DIAG_DEPTH = 38;
   localparam int COND_DEPTH = 10;
   localparam int N_LVL      = 6;
   localparam int N_HOLD     = 4;
   localparam int N_SRC      = N_LVL + N_HOLD;
   localparam int N_EVT      = 4;

   // ---------------------------------------------------------------
   // Diagnostic type codes
   // ---------------------------------------------------------------
   localparam logic [15:0] C_SHORT_ON    = 16'h120C;
   localparam logic [15:0] C_SHORT_OFF   = 16'h020C;
   localparam logic [15:0] C_OVERV_ON    = 16'h1211;
   localparam logic [15:0] C_OVERV_OFF   = 16'h0211;
   localparam logic [15:0] C_PRESS_ON    = 16'h1212;
   localparam logic [15:0] C_PRESS_OFF   = 16'h0212;
   localparam logic [15:0] C_FREEF_ON    = 16'h1110;
   localparam logic [15:0] C_FREEF_OFF   = 16'h0110;
   localparam logic [15:0] C_NONOPT_ON   = 16'h1120;
   localparam logic [15:0] C_NONOPT_OFF  = 16'h0120;
   localparam logic [15:0] C_PRCM_ON     = 16'h1180;
   localparam logic [15:0] C_PRCM_OFF    = 16'h0180;
   localparam logic [15:0] C_VALVE_WARN  = 16'h1101;
   localparam logic [15:0] C_EVAC_WARN   = 16'h1102;
   localparam logic [15:0] C_LEAK_WARN   = 16'h1104;
   localparam logic [15:0] C_NOSP_WARN   = 16'h1108;

   // Index 0 has the highest logging priority
   localparam logic [N_LVL-1:0][15:0] LVL_ON_CODE =
      {C_PRCM_ON, C_NONOPT_ON, C_FREEF_ON, C_PRESS_ON, C_OVERV_ON, C_SHORT_ON};
   localparam logic [N_LVL-1:0][15:0] LVL_OFF_CODE =
      {C_PRCM_OFF, C_NONOPT_OFF, C_FREEF_OFF, C_PRESS_OFF, C_OVERV_OFF, C_SHORT_OFF};
   localparam logic [N_HOLD-1:0][15:0] HOLD_CODE =
      {C_NOSP_WARN, C_LEAK_WARN, C_EVAC_WARN, C_VALVE_WARN};

   // ---------------------------------------------------------------
   // Protocol events
   // ---------------------------------------------------------------
   localparam logic [15:0] E_INTERNAL  = 16'h1000;
   localparam logic [15:0] E_UNDERV    = 16'h5100;
   localparam logic [15:0] E_OVERV     = 16'h5110;
   localparam logic [15:0] E_SYSPRESS  = 16'h1802;
   localparam logic [N_EVT-1:0][15:0] EVT_CODE  = {E_SYSPRESS, E_OVERV, E_UNDERV, E_INTERNAL};
   localparam logic [N_EVT-1:0]       EVT_ERROR = 4'h3;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] code;
      logic [31:0] count;
   } dl_diag_entry_t;

   typedef struct packed {
      logic [15:0] evac;
      logic [15:0] leak;
      logic [15:0] freeflow;
      logic [31:0] count;
   } dl_cond_entry_t;

   typedef struct packed {
      logic        done;
      logic        sp_reached;
      logic [15:0] evac;
      logic [15:0] leak;
      logic [15:0] freeflow;
   } dl_cycle_rpt_t;

   typedef struct packed {
      logic        valid;
      logic        is_error;
      logic [15:0] code;
   } dl_event_t;

   localparam dl_diag_entry_t DIAG_RST  = '0;
   localparam dl_cond_entry_t COND_RST  = '0;
   localparam dl_event_t      EVENT_RST = '0;

endpackage

// *** verilog/dl_logger.sv ***
// Diagnostic and condition-data logger with protocol event raising.
// Assumes all inputs synchronous to CLK_SYS; cycle reports are one-cycle pulses.
//
// Behaviour
// R1 - Log 0x120C on output short onset, 0x020C when it clears.
// R2 - Log 0x1211 on supply overvoltage onset, 0x0211 on clearance.
// R3 - Log 0x1212 when input pressure leaves range, 0x0212 on return.
// R4 - Valve protection logs 0x1101; warning held until next suction cycle.
// R5 - Evacuation time over limit logs 0x1102, held until next cycle.
// R6 - Leakage over limit logs 0x1104, held until next cycle.
// R7 - Upper setpoint missed in a cycle logs 0x1108, held until next cycle.
// R8 - Free-flow between threshold-minus-hysteresis and setpoint logs 0x1110, end 0x0110.
// R9 - Supply outside optimal range logs 0x1120, return logs 0x0120.
// R10 - Input pressure out of range logs 0x1180, return logs 0x0180.
// R11 - Condition entry: evac, leakage, free-flow, counter; MSB first.
// R12 - Condition history holds ten entries, newest first.
// R13 - Internal error raises event 0x1000 of error type.
// R14 - Supply undervoltage raises event 0x5100 of error type.
// R15 - Supply overvoltage raises event 0x5110 of warning type.
// R16 - System pressure out of range raises event 0x1802, warning type.
// R17 - Diagnostic entry: type code then cycle counter, MSB first.
// R18 - Diagnostic history holds 38 entries, newest first.
// R19 - New entry enters newest slot, oldest entry drops out.
`timescale 1ns/1ns
module dl_logger
   import dl_pkg::*;
(
   // Clock and reset
   input  wire logic           CLK_SYS,
   input  wire logic           RST,
   // Condition levels
   input  wire logic           OUTPUT_SHORT,
   input  wire logic           SUPPLY_OVERVOLT,
   input  wire logic           SUPPLY_UNDERVOLT,
   input  wire logic           SUPPLY_NOT_OPTIMAL,
   input  wire logic           INPUT_PRESSURE_BAD,
   input  wire logic           INTERNAL_ERROR,
   // Suction cycle
   input  wire logic           CYCLE_START,
   input  wire logic           VALVE_PROTECT,
   input  wire dl_cycle_rpt_t  CYCLE_RPT,
   input  wire logic [31:0]    CYCLE_COUNTER,
   // Limits and thresholds
   input  wire logic [15:0]    EVAC_TIME_LIMIT,
   input  wire logic [15:0]    LEAKAGE_LIMIT,
   input  wire logic [15:0]    UPPER_CONTROL_SETPOINT,
   input  wire logic [15:0]    PART_PRESENT_THRESHOLD,
   input  wire logic [15:0]    PART_PRESENT_HYSTERESIS,
   // History reads
   input  wire logic [5:0]     DIAG_RD_IDX,
   output dl_diag_entry_t      DIAG_RD_DATA,
   input  wire logic [3:0]     COND_RD_IDX,
   output dl_cond_entry_t      COND_RD_DATA,
   // Status and events
   output logic [N_HOLD-1:0]   WARN_HELD,
   output dl_event_t           EVENT
);

   // ---------------------------------------------------------------
   // Shared decode
   // ---------------------------------------------------------------
   // Lowest set bit wins; bit 4 of the result flags a hit
   function automatic logic [4:0] first_set(input logic [15:0] v);
      logic [4:0] r;
      r = '0;
      for (int i = 15; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Condition sources
   // ---------------------------------------------------------------
   logic [15:0]        freeflow_q;
   logic [15:0]        thr_low;
   logic               marginal;
   logic [N_LVL-1:0]   lvl_cur;
   logic [N_LVL-1:0]   lvl_logged_q;
   logic [N_HOLD-1:0]  hold_trig;
   logic [N_HOLD-1:0]  pend_q;
   logic [N_HOLD-1:0]  warn_q;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         freeflow_q <= 16'h0000;
      end else if (CYCLE_RPT.done) begin
         freeflow_q <= CYCLE_RPT.freeflow;
      end
   end

   // R8 free-flow window
   // Clamp avoids wrap when hysteresis exceeds threshold
   assign thr_low  = (PART_PRESENT_THRESHOLD > PART_PRESENT_HYSTERESIS) ?
                     PART_PRESENT_THRESHOLD - PART_PRESENT_HYSTERESIS : 16'h0000;
   assign marginal = (freeflow_q > thr_low) && (freeflow_q < UPPER_CONTROL_SETPOINT);

   // R1 R2 R3 R9 R10 level sources
   assign lvl_cur = {INPUT_PRESSURE_BAD, SUPPLY_NOT_OPTIMAL, marginal,
                     INPUT_PRESSURE_BAD, SUPPLY_OVERVOLT, OUTPUT_SHORT};

   // R5 R6 R7 cycle-end checks
   assign hold_trig = {CYCLE_RPT.done & ~CYCLE_RPT.sp_reached,
                       CYCLE_RPT.done & (CYCLE_RPT.leak > LEAKAGE_LIMIT),
                       CYCLE_RPT.done & (CYCLE_RPT.evac > EVAC_TIME_LIMIT),
                       VALVE_PROTECT};

   // ---------------------------------------------------------------
   // Entry selection
   // ---------------------------------------------------------------
   // One entry per cycle; levels outrank held warnings. A change waits
   // its turn; a level that reverts before then is never logged.
   logic [4:0]   sel;
   logic         log_v;
   logic [3:0]   log_i;
   logic [15:0]  log_code;

   assign sel   = first_set(16'({pend_q, lvl_cur ^ lvl_logged_q}));
   assign log_v = sel[4];
   assign log_i = sel[3:0];

   always_comb begin
      log_code = 16'h0000;
      if (log_i < 4'(N_LVL)) begin
         log_code = lvl_cur[log_i[2:0]] ? LVL_ON_CODE[log_i[2:0]] : LVL_OFF_CODE[log_i[2:0]];
      end else begin
         log_code = HOLD_CODE[2'(log_i - 4'(N_LVL))];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         lvl_logged_q <= '0;
      end else if (log_v && log_i < 4'(N_LVL)) begin
         lvl_logged_q[log_i[2:0]] <= lvl_cur[log_i[2:0]];
      end
   end

   // R4 R5 R6 R7 hold until next cycle
   // New trigger beats both the logging clear and the cycle-start clear
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         pend_q <= '0;
         warn_q <= '0;
      end else begin
         for (int i = 0; i < N_HOLD; i++) begin
            if (hold_trig[i]) begin
               pend_q[i] <= 1'b1;
               warn_q[i] <= 1'b1;
            end else begin
               if (log_v && log_i == 4'(N_LVL + i)) begin
                  pend_q[i] <= 1'b0;
               end
               if (CYCLE_START) begin
                  warn_q[i] <= 1'b0;
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Diagnostic history
   // ---------------------------------------------------------------
   dl_diag_entry_t diag_q [DIAG_DEPTH];

   // R17 R19 insert newest
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         diag_q[0] <= DIAG_RST;
      end else if (log_v) begin
         diag_q[0] <= '{code: log_code, count: CYCLE_COUNTER};
      end
   end

   // R18 R19 oldest falls off
   for (genvar g = 1; g < DIAG_DEPTH; g++) begin : g_diag
      always_ff @(posedge CLK_SYS) begin
         if (RST) begin
            diag_q[g] <= DIAG_RST;
         end else if (log_v) begin
            diag_q[g] <= diag_q[g-1];
         end
      end
   end

   // ---------------------------------------------------------------
   // Condition-data history
   // ---------------------------------------------------------------
   dl_cond_entry_t cond_q [COND_DEPTH];

   // R11 record per cycle
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         cond_q[0] <= COND_RST;
      end else if (CYCLE_RPT.done) begin
         cond_q[0] <= '{evac: CYCLE_RPT.evac, leak: CYCLE_RPT.leak,
                        freeflow: CYCLE_RPT.freeflow, count: CYCLE_COUNTER};
      end
   end

   // R12 newest first
   for (genvar g = 1; g < COND_DEPTH; g++) begin : g_cond
      always_ff @(posedge CLK_SYS) begin
         if (RST) begin
            cond_q[g] <= COND_RST;
         end else if (CYCLE_RPT.done) begin
            cond_q[g] <= cond_q[g-1];
         end
      end
   end

   // ---------------------------------------------------------------
   // Read ports
   // ---------------------------------------------------------------
   // Index 0 is the newest; out-of-range indices read zero
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         DIAG_RD_DATA <= DIAG_RST;
         COND_RD_DATA <= COND_RST;
      end else begin
         DIAG_RD_DATA <= (DIAG_RD_IDX < 6'(DIAG_DEPTH)) ? diag_q[DIAG_RD_IDX] : DIAG_RST;
         COND_RD_DATA <= (COND_RD_IDX < 4'(COND_DEPTH)) ? cond_q[COND_RD_IDX] : COND_RST;
      end
   end

   assign WARN_HELD = warn_q;

   // ---------------------------------------------------------------
   // Protocol events
   // ---------------------------------------------------------------
   logic [N_EVT-1:0] evt_cur;
   logic [N_EVT-1:0] evt_seen_q;
   logic [4:0]       esel;

   // R13 R14 R15 R16 event sources
   assign evt_cur = {INPUT_PRESSURE_BAD, SUPPLY_OVERVOLT, SUPPLY_UNDERVOLT, INTERNAL_ERROR};
   assign esel    = first_set(16'(evt_cur ^ evt_seen_q));

   // Only onsets are raised; clearances just rearm the source
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         evt_seen_q <= '0;
         EVENT      <= EVENT_RST;
      end else begin
         EVENT <= EVENT_RST;
         if (esel[4]) begin
            evt_seen_q[esel[1:0]] <= evt_cur[esel[1:0]];
            if (evt_cur[esel[1:0]]) begin
               EVENT <= '{valid: 1'b1, is_error: EVT_ERROR[esel[1:0]],
                          code: EVT_CODE[esel[1:0]]};
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   property p_short_code;
      log_v && log_i == 4'h0 |=> diag_q[0].code == ($past(OUTPUT_SHORT) ? 16'h120C : 16'h020C);
   endproperty
   a_short_code: assert property (p_short_code) else $error("short code wrong"); // R1

   property p_overv_code;
      log_v && log_i == 4'h1 && !SUPPLY_OVERVOLT |=> diag_q[0].code == 16'h0211;
   endproperty
   a_overv_code: assert property (p_overv_code) else $error("overvolt clear code wrong"); // R2

   property p_press_pair;
      log_v && log_i == 4'h5 && INPUT_PRESSURE_BAD |=> diag_q[0].code == 16'h1180;
   endproperty
   a_press_pair: assert property (p_press_pair) else $error("pressure CM code wrong"); // R10

   property p_valve_hold;
      VALVE_PROTECT ##1 !CYCLE_START [*3] |-> WARN_HELD[0];
   endproperty
   a_valve_hold: assert property (p_valve_hold) else $error("valve warning dropped"); // R4

   property p_evac_log;
      CYCLE_RPT.done && CYCLE_RPT.evac > EVAC_TIME_LIMIT
         |-> ##[1:12] diag_q[0].code == 16'h1102;
   endproperty
   a_evac_log: assert property (p_evac_log) else $error("evac warning not logged"); // R5

   property p_cond_entry;
      CYCLE_RPT.done |=> cond_q[0] == {$past(CYCLE_RPT.evac), $past(CYCLE_RPT.leak),
                                       $past(CYCLE_RPT.freeflow), $past(CYCLE_COUNTER)};
   endproperty
   a_cond_entry: assert property (p_cond_entry) else $error("condition entry wrong"); // R11

   property p_cond_shift;
      CYCLE_RPT.done |=> cond_q[9] == $past(cond_q[8]);
   endproperty
   a_cond_shift: assert property (p_cond_shift) else $error("condition history shift"); // R12

   property p_diag_shift;
      log_v |=> diag_q[37] == $past(diag_q[36]) && diag_q[0].count == $past(CYCLE_COUNTER);
   endproperty
   a_diag_shift: assert property (p_diag_shift) else $error("diagnostic history shift"); // R18

   property p_internal_evt;
      $rose(INTERNAL_ERROR) |=> EVENT.valid && EVENT.code == 16'h1000 && EVENT.is_error;
   endproperty
   a_internal_evt: assert property (p_internal_evt) else $error("internal event missing"); // R13

   property p_overv_evt;
      EVENT.valid && EVENT.code == 16'h5110 |-> !EVENT.is_error && $past(SUPPLY_OVERVOLT);
   endproperty
   a_overv_evt: assert property (p_overv_evt) else $error("overvolt event wrong"); // R15

   c_two_logs:   cover property (log_v [*2]);
   c_hold_clear: cover property (WARN_HELD[1] ##1 CYCLE_START ##1 !WARN_HELD[1]);
   c_press_evt:  cover property (EVENT.valid && EVENT.code == E_SYSPRESS);

endmodule

// *** verification/dl_master_model.sv ***
// Far-side model: reads both histories by index and collects raised events.
// Assumes the logger answers a read index one clock edge later.
`timescale 1ns/1ns
module dl_master_model
   import dl_pkg::*;
(
   // Clock
   input  wire logic           clk,
   // History reads
   output logic [5:0]          diag_idx,
   input  wire dl_diag_entry_t diag_data,
   output logic [3:0]          cond_idx,
   input  wire dl_cond_entry_t cond_data,
   // Events
   input  wire dl_event_t      event_in
);
   dl_event_t evq[$];

   initial begin
      diag_idx = 6'h00;
      cond_idx = 4'h0;
   end

   // Valid is a one-cycle pulse, so every edge is looked at
   always @(posedge clk) begin
      if (event_in.valid === 1'b1) begin
         evq.push_back(event_in);
      end
   end

   task automatic read_diag(input logic [5:0] i, output dl_diag_entry_t d);
      @(posedge clk);
      diag_idx <= i;
      repeat (2) @(posedge clk);
      #1 d = diag_data;
   endtask

   task automatic read_cond(input logic [3:0] i, output dl_cond_entry_t d);
      @(posedge clk);
      cond_idx <= i;
      repeat (2) @(posedge clk);
      #1 d = cond_data;
   endtask
endmodule

// *** verification/dl_logger_tb.sv ***
// Self-checking bench for the diagnostic event logger.
// Assumes the master model file is compiled before this one.
`timescale 1ns/1ns
module dl_logger_tb
   import dl_pkg::*;
;
   logic clk_sys, rst, out_short, ov, uv, nopt, pbad, ierr, cstart, valve, ff_on;
   dl_cycle_rpt_t   rpt;
   logic [31:0]     cnt, cur;
   logic [5:0]      diag_idx;
   logic [3:0]      cond_idx, warn;
   logic [15:0]     thr, hyst;
   dl_diag_entry_t  diag_data, d;
   dl_cond_entry_t  cond_data, c;
   dl_event_t       evt;
   dl_diag_entry_t  exp_d[$];
   dl_cond_entry_t  exp_c[$];
   int              bad_count, samples_checked, i;

   always #5 clk_sys = ~clk_sys;

   dl_logger dl_logger_inst (
      .CLK_SYS(clk_sys), .RST(rst), .OUTPUT_SHORT(out_short), .SUPPLY_OVERVOLT(ov),
      .SUPPLY_UNDERVOLT(uv), .SUPPLY_NOT_OPTIMAL(nopt), .INPUT_PRESSURE_BAD(pbad),
      .INTERNAL_ERROR(ierr), .CYCLE_START(cstart), .VALVE_PROTECT(valve), .CYCLE_RPT(rpt),
      .CYCLE_COUNTER(cnt), .EVAC_TIME_LIMIT(16'h8000), .LEAKAGE_LIMIT(16'h8000),
      .UPPER_CONTROL_SETPOINT(16'h5000), .PART_PRESENT_THRESHOLD(thr),
      .PART_PRESENT_HYSTERESIS(hyst), .DIAG_RD_IDX(diag_idx), .DIAG_RD_DATA(diag_data),
      .COND_RD_IDX(cond_idx), .COND_RD_DATA(cond_data), .WARN_HELD(warn), .EVENT(evt));

   dl_master_model dl_master_model_inst (
      .clk(clk_sys), .diag_idx(diag_idx), .diag_data(diag_data), .cond_idx(cond_idx),
      .cond_data(cond_data), .event_in(evt));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Counter held steady until the change is logged
   task automatic nc();
      cur = $urandom();
      cnt <= cur;
      tick(1);
   endtask

   task automatic log(input logic [15:0] code);
      exp_d.push_front('{code, cur});
   endtask

   task automatic expect_event(input logic err, input logic [15:0] code);
      dl_event_t e;
      for (int k = 0; k < 20 && dl_master_model_inst.evq.size() == 0; k++) tick(1);
      if (dl_master_model_inst.evq.size() == 0) begin
         bad_count++;
         $display("wrong value event expected %h seen none", code);
         final_report();
      end else begin
         e = dl_master_model_inst.evq.pop_front();
         check("event", {62'h0, e}, {62'h0, 1'b1, err, code});
      end
   endtask

   // Lower edge of the window never wraps below zero
   function automatic logic ff_marg(input logic [15:0] ff);
      logic [15:0] lo;
      lo = (hyst < thr) ? 16'(thr - hyst) : 16'h0000;
      return ff > lo && ff < 16'h5000;
   endfunction

   task automatic report(input logic [15:0] ev, lk, ff, input logic sp, vp);
      logic [3:0] w;
      nc();
      cstart <= 1'b1;
      tick(1);
      cstart <= 1'b0;
      tick(3);
      check("warn_cleared", {76'h0, warn}, 80'h0);
      w = {!sp, lk > 16'h8000, ev > 16'h8000, vp};
      if (vp) begin
         valve <= 1'b1;
         tick(1);
         valve <= 1'b0;
         log(C_VALVE_WARN);
         tick(3);
      end
      rpt <= '{1'b1, sp, ev, lk, ff};
      tick(1);
      rpt.done <= 1'b0;
      // Free-flow level change outranks the held warnings
      if (ff_marg(ff) != ff_on) begin
         ff_on = ff_marg(ff);
         log(ff_on ? C_FREEF_ON : C_FREEF_OFF);
      end
      for (int k = 1; k < 4; k++) if (w[k]) log(HOLD_CODE[k]);
      exp_c.push_front('{ev, lk, ff, cur});
      tick(12);
      check("warn_held", {76'h0, warn}, {76'h0, w});
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {clk_sys, out_short, ov, uv, nopt, pbad, ierr, cstart, valve, ff_on} = '0;
      rst = 1'b1;
      rpt = '0;
      cnt = 32'h0;
      cur = 32'h0;
      thr = 16'h3000;
      hyst = 16'h1000;
      bad_count = 0;
      samples_checked = 0;
      void'($urandom(32'h0faad76a));
      tick(12);
      rst <= 1'b0;
      tick(2);

      nc(); out_short <= 1'b1; log(C_SHORT_ON); tick(12);
      nc(); out_short <= 1'b0; log(C_SHORT_OFF); tick(12);
      nc(); ov <= 1'b1; log(C_OVERV_ON); tick(12);
      expect_event(1'b0, E_OVERV);
      nc(); ov <= 1'b0; log(C_OVERV_OFF); tick(12);
      nc(); nopt <= 1'b1; log(C_NONOPT_ON); tick(12);
      nc(); nopt <= 1'b0; log(C_NONOPT_OFF); tick(12);
      $display("test supply and short done");

      // Pressure change yields the error code, then the monitoring code
      nc(); pbad <= 1'b1; log(C_PRESS_ON); log(C_PRCM_ON); tick(12);
      expect_event(1'b0, E_SYSPRESS);
      nc(); pbad <= 1'b0; log(C_PRESS_OFF); log(C_PRCM_OFF); tick(12);
      check("no_clear_event", 80'(dl_master_model_inst.evq.size()), 80'h0);
      $display("test pressure done");

      // Simultaneous onsets: internal error outranks undervoltage
      uv <= 1'b1;
      ierr <= 1'b1;
      expect_event(1'b1, E_INTERNAL);
      expect_event(1'b1, E_UNDERV);
      uv <= 1'b0;
      ierr <= 1'b0;
      tick(4);
      $display("test events done");

      // Boundary values of the limits and the free-flow window
      report(16'h8000, 16'h8001, 16'h2000, 1'b1, 1'b1);
      report(16'h8001, 16'h8000, 16'h2001, 1'b1, 1'b0); // onset
      report(16'h0100, 16'h0100, 16'h5000, 1'b0, 1'b0); // end
      // Hysteresis above threshold: window floor clamps to zero
      thr <= 16'h0800;
      hyst <= 16'h1000;
      tick(2);
      report(16'h0100, 16'h0100, 16'h0001, 1'b1, 1'b0); // clamp
      for (i = 0; i < 12; i++) begin
         report(16'($urandom()), 16'($urandom()), 16'h6000 + 16'($urandom() % 16'h1000),
                1'($urandom()), 1'($urandom() % 3 == 0));
      end
      $display("test cycle reports done");

      for (i = 0; i < 8; i++) begin
         nc(); out_short <= 1'b1; log(C_SHORT_ON); tick(3);
         nc(); out_short <= 1'b0; log(C_SHORT_OFF); tick(3);
      end
      tick(10);

      for (i = 0; i < 38; i++) begin
         dl_master_model_inst.read_diag(6'(i), d);
         check("diag_entry", {32'h0, d}, {32'h0, exp_d[i]});
      end
      dl_master_model_inst.read_diag(6'd38, d);
      check("diag_beyond", {32'h0, d}, 80'h0);
      for (i = 0; i < 10; i++) begin
         dl_master_model_inst.read_cond(4'(i), c);
         check("cond_entry", c, exp_c[i]);
      end
      dl_master_model_inst.read_cond(4'hA, c);
      check("cond_beyond", c, 80'h0);
      $display("test history readback done");
      final_report();
   end
endmodule
